//--- logic/qbsr_top.sv
`timescale 1ns/1ns
`default_nettype none
module qbsr_top
  import qbsr_pkg::*;
#(
  parameter int LEN = qbsr_pkg::QBSR_LEN_LONG
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic shift_clk_in,
  input wire logic async_clear_in,
  input wire qbsr_pkg::qbsr_ctrl_t ctrl_in,
  input wire qbsr_pkg::qbsr_lanes_t data_in,
  output qbsr_pkg::qbsr_lanes_t serial_out,
  output qbsr_pkg::qbsr_lanes_t flag_out
);
  import qbsr_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // All pins are asynchronous to ref_clk_in; two flops each
  localparam int SYNC_W = 10;
  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic [SYNC_W-1:0] meta_nxt;
  logic [SYNC_W-1:0] sync_nxt;
  logic shift_clk_d_r;
  logic shift_clk_d_nxt;

  always_comb begin
    meta_nxt = {shift_clk_in, async_clear_in, ctrl_in, data_in};
    sync_nxt = meta_r;
    shift_clk_d_nxt = sync_r[SYNC_W-1];
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_r <= '0;
      sync_r <= '0;
      shift_clk_d_r <= 1'h0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      shift_clk_d_r <= shift_clk_d_nxt;
    end
  end

  // Synchronised copies; the unpacking order matches meta_nxt above
  qbsr_ctrl_t ctrl_s;
  qbsr_lanes_t data_s;
  logic clk_s;
  logic clear_s;
  logic shift_step;
  logic left_s;

  assign {clk_s, clear_s, ctrl_s, data_s} = sync_r;
  // One step per rising edge of the shift clock; clock held = no step
  // The edge is found on the synchronised copy, so one slow pin edge
  // gives exactly one step, never two
  assign shift_step = clk_s & ~shift_clk_d_r;
  assign left_s = (ctrl_s.shift_direction_select == QBSR_DIR_LEFT);

  // ------------------------------------------------------------
  // Control decode
  // ------------------------------------------------------------
  // Named copies keep the selection logic below readable
  logic recirc_abc_s;
  logic recirc_fourth_s;
  logic recirc_bit_s;

  assign recirc_abc_s = ctrl_s.recirc_ctrl_abc;
  assign recirc_fourth_s = ctrl_s.recirc_ctrl_fourth;
  assign recirc_bit_s = ctrl_s.recirc_data_in_fourth;

  // Cleared image of all lanes; shared by both output groups
  function automatic qbsr_lanes_t cleared_lanes();
    return qbsr_lanes_t'({QBSR_NUM_REGS{QBSR_CLEAR_BIT}});
  endfunction

  // ------------------------------------------------------------
  // Lane input selection
  // ------------------------------------------------------------
  // Recirculation of the first three lanes loops each lane's own output, so it works in both directions
  // Limitation: the looped bit is the exit stage of the current
  // direction, so turning round while recirculating changes which
  // end of the lane is fed back
  qbsr_lanes_t lane_q;
  qbsr_lanes_t lane_flag;
  qbsr_lanes_t lane_d;

  always_comb begin
    lane_d = data_s;
    if (recirc_abc_s) begin
      lane_d.first = lane_q.first;
      lane_d.second = lane_q.second;
      lane_d.third = lane_q.third;
    end
    if (recirc_fourth_s) begin
      lane_d.fourth = recirc_bit_s;
    end
  end

  // ------------------------------------------------------------
  // Four lanes
  // ------------------------------------------------------------
  // All lanes share step, direction and clear; only data differs
  // First lane
  qbsr_lane #(
    .LEN(LEN)
  ) u_first (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(clear_s),
    .shift_in(shift_step),
    .left_in(left_s),
    .data_in(lane_d.first),
    .serial_out(lane_q.first),
    .flag_out(lane_flag.first)
  );

  // Second lane
  qbsr_lane #(
    .LEN(LEN)
  ) u_second (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(clear_s),
    .shift_in(shift_step),
    .left_in(left_s),
    .data_in(lane_d.second),
    .serial_out(lane_q.second),
    .flag_out(lane_flag.second)
  );

  // Third lane
  qbsr_lane #(
    .LEN(LEN)
  ) u_third (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(clear_s),
    .shift_in(shift_step),
    .left_in(left_s),
    .data_in(lane_d.third),
    .serial_out(lane_q.third),
    .flag_out(lane_flag.third)
  );

  // Fourth lane, the one with its own recirculate input
  qbsr_lane #(
    .LEN(LEN)
  ) u_fourth (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clear_in(clear_s),
    .shift_in(shift_step),
    .left_in(left_s),
    .data_in(lane_d.fourth),
    .serial_out(lane_q.fourth),
    .flag_out(lane_flag.fourth)
  );

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  // Clear forces outputs low from the raw pin without waiting for
  // the synchroniser; registered lane outputs follow shift timing
  // Trade-off: the raw clear adds an asynchronous input to these
  // flops, but the pins drop the moment clear rises
  qbsr_lanes_t serial_nxt;
  qbsr_lanes_t flag_nxt;

  always_comb begin
    serial_nxt = clear_s ? cleared_lanes() : lane_q;
    flag_nxt = clear_s ? cleared_lanes() : lane_flag;
  end

  // Serial outputs; reset first, then clear, then the next value
  always_ff @(posedge ref_clk_in or negedge reset_n_in or posedge async_clear_in) begin
    if (!reset_n_in) begin
      serial_out <= '0;
    end else if (async_clear_in) begin
      serial_out <= '0;
    end else begin
      serial_out <= serial_nxt;
    end
  end

  // Flag outputs, always the last stage whatever the direction
  always_ff @(posedge ref_clk_in or negedge reset_n_in or posedge async_clear_in) begin
    if (!reset_n_in) begin
      flag_out <= '0;
    end else if (async_clear_in) begin
      flag_out <= '0;
    end else begin
      flag_out <= flag_nxt;
    end
  end

endmodule // qbsr_top
`default_nettype wire

//--- logic/qbsr_pkg.sv
package qbsr_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int QBSR_LEN_LONG = 133;  // Long variant length
  localparam int QBSR_LEN_SHORT = 81;  // Short variant length
  localparam int QBSR_NUM_REGS = 4;
  localparam logic QBSR_CLEAR_BIT = 1'h0;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic first;
    logic second;
    logic third;
    logic fourth;
  } qbsr_lanes_t;

  typedef struct packed {
    logic shift_direction_select;  // 0 right / load, 1 left
    logic recirc_ctrl_abc;
    logic recirc_ctrl_fourth;
    logic recirc_data_in_fourth;
  } qbsr_ctrl_t;

  // Direction codes
  typedef enum logic [0:0] {
    QBSR_DIR_RIGHT = 1'h0,
    QBSR_DIR_LEFT = 1'h1
  } qbsr_dir_t;

endpackage

//--- logic/qbsr_lane.sv
`timescale 1ns/1ns
`default_nettype none
module qbsr_lane #(
  parameter int LEN = 133
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic clear_in,
  input wire logic shift_in,
  input wire logic left_in,
  input wire logic data_in,
  output logic serial_out,
  output logic flag_out
);
  import qbsr_pkg::*;

  logic [LEN-1:0] stage_r;
  logic [LEN-1:0] stage_nxt;

  // ------------------------------------------------------------
  // Stage array
  // ------------------------------------------------------------
  // Right shift enters at stage 0; left shift enters at the far end so
  // the most recent bits come back first, giving stack order
  always_comb begin
    stage_nxt = stage_r;
    if (clear_in) begin
      stage_nxt = '0;
    end else if (shift_in) begin
      if (left_in) begin
        stage_nxt = {data_in, stage_r[LEN-1:1]};
      end else begin
        stage_nxt = {stage_r[LEN-2:0], data_in};
      end
    end
  end

  // Static storage: with no shift and no clear the stages simply hold
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  // Serial output is the stage on the exit side of the current direction; flag is always the last stage
  assign serial_out = left_in ? stage_r[0] : stage_r[LEN-1];
  assign flag_out = stage_r[LEN-1];

endmodule // qbsr_lane
`default_nettype wire

//--- verif/qbsr_far_end.sv
`timescale 1ns/1ns
`default_nettype none
module qbsr_far_end (
  input wire logic ref_clk_in,
  input wire logic go_in,
  output logic shift_clk_out
);
  logic [2:0] cnt_r = 3'h0;
  // Counts one step out; a wrap back to zero ends it
  always @(posedge ref_clk_in) begin
    if (cnt_r != 3'h0 || go_in) cnt_r <= cnt_r + 3'h1;
  end
  // Clock rests low, one pulse of three cycles for each step
  assign shift_clk_out = cnt_r != 3'h0 && !cnt_r[2];
endmodule // qbsr_far_end
`default_nettype wire

//--- verif/qbsr_properties.sv
`timescale 1ns/1ns
`default_nettype none
module qbsr_properties
  import qbsr_pkg::*;
#(parameter int LEN = 133) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic shift_clk_in,
  input wire logic async_clear_in,
  input wire qbsr_pkg::qbsr_ctrl_t ctrl_in,
  input wire qbsr_pkg::qbsr_lanes_t data_in,
  input wire qbsr_pkg::qbsr_lanes_t serial_out,
  input wire qbsr_pkg::qbsr_lanes_t flag_out
);
  // One domain, so clock and reset stand once
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  chk_clear_low: assert property (async_clear_in |-> serial_out == 4'h0 && flag_out == 4'h0)
    else $error("clear");
  chk_idle_hold: assert property ((!async_clear_in && $stable(shift_clk_in)) [*8] |-> $stable({serial_out, flag_out}))
    else $error("hold");
  chk_step_cause: assert property (!async_clear_in && $changed(serial_out) |-> $past(shift_clk_in, 4) ||
    $past(ctrl_in.shift_direction_select, 3) != $past(ctrl_in.shift_direction_select, 4))
    else $error("cause");
  chk_one_step: assert property (!async_clear_in && $changed(flag_out) ##1 !async_clear_in |-> $stable(flag_out))
    else $error("twice");
  chk_resume_zero: assert property ($fell(async_clear_in) && !shift_clk_in |-> (serial_out == 4'h0) [*3])
    else $error("resume");
  chk_left_load: assert property ($rose(shift_clk_in) && ctrl_in == 4'h8 ##1 !async_clear_in [*6] |->
    flag_out.first == $past(data_in.first, 6)) else $error("left");
  chk_abc_recirc: assert property ($rose(shift_clk_in) && ctrl_in[3:2] == 2'h3 ##1 !async_clear_in [*6] |->
    flag_out.second == $past(serial_out.second, 4)) else $error("recirc");
  chk_fourth_recirc: assert property ($rose(shift_clk_in) && ctrl_in[3] && ctrl_in[1] ##1 !async_clear_in [*6] |->
    flag_out.fourth == $past(ctrl_in.recirc_data_in_fourth, 6)) else $error("fourth");
endmodule // qbsr_properties
bind qbsr_top qbsr_properties #(.LEN(LEN)) chk (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .shift_clk_in(shift_clk_in), .async_clear_in(async_clear_in), .ctrl_in(ctrl_in), .data_in(data_in),
  .serial_out(serial_out), .flag_out(flag_out));
`default_nettype wire

//--- verif/quad_bidir_static_shift_register_test.sv
`timescale 1ns/1ns
`default_nettype none
module quad_bidir_static_shift_register_test;
  import qbsr_pkg::*;
  localparam int LEN = QBSR_LEN_SHORT;
  logic ref_clk, reset_n, go, clr, sclk;
  qbsr_ctrl_t ctrl;
  qbsr_lanes_t din, sout, fout;
  logic [LEN-1:0] m [4];
  logic [3:0] eo, ef;
  int miscompares, num_checks, cyc;
  qbsr_top #(.LEN(LEN)) dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .shift_clk_in(sclk),
    .async_clear_in(clr), .ctrl_in(ctrl), .data_in(din), .serial_out(sout), .flag_out(fout));
  qbsr_far_end far (.ref_clk_in(ref_clk), .go_in(go), .shift_clk_out(sclk));
  // System clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Bit entering lane k; recirculation reads the exit stage of the new direction
  function automatic logic lane_in(int k, logic [3:0] c, logic [3:0] d);
    return (k > 0 && c[2]) ? (c[3] ? m[k][0] : m[k][LEN-1]) : (k == 0 && c[1]) ? c[0] : d[k];
  endfunction
  task automatic check(string n, logic [3:0] s, logic [3:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  // One step; inputs held a whole pulse so the sync stages see them settled
  task automatic step(logic [3:0] c, logic [3:0] d);
    ctrl <= c;
    din <= d;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (10) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      if (!clr) m[k] = c[3] ? {lane_in(k, c, d), m[k][LEN-1:1]} : {m[k][LEN-2:0], lane_in(k, c, d)};
      eo[k] = c[3] ? m[k][0] : m[k][LEN-1];
      ef[k] = m[k][LEN-1];
    end
    check("serial", sout, eo);
    check("flag", fout, ef);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Cycle ceiling cuts a hung run short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(74));
    {reset_n, go, clr, ctrl, din, eo} = '0;
    foreach (m[k]) m[k] = '0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("reset", sout, 4'h0);
    // Fill rightward, then read back leftward in stack order
    for (int i = 0; i < 2 * LEN; i++) step((i < LEN) ? 4'h0 : 4'h8, 4'($urandom));
    for (int i = 0; i < 200; i++) step(4'($urandom), 4'($urandom));
    // Parked clock with wandering data must keep contents
    din <= qbsr_lanes_t'(~din);
    repeat (30) @(posedge ref_clk);
    check("hold", sout, eo);
    // Clear over a step wins; lanes restart from zero
    clr <= 1'b1;
    foreach (m[k]) m[k] = '0;
    step(4'($urandom), 4'hF);
    clr <= 1'b0;
    for (int i = 0; i < 4; i++) step(4'h8, 4'hF);
    print_verdict();
  end
endmodule // quad_bidir_static_shift_register_test
`default_nettype wire
